//--- verilog/aec_cfg.svh
/*
  Constants of the alarm front-end enable control block: register offsets,
  field positions, reset values and timing figures.
  Assumes a 40 MHz core clock and a 32-bit APB register bus.
*/
// Functional notes
// - LED sink runs only when gate high and enable pin or enabled GPIO pin high
// - Select bit routes enable pin to A or B
// - GPIO pin may enable either LED driver
// - Each LED driver has its own 8-bit code
// - Per-driver two-bit temperature compensation field
// - Read-only sense bin reported at offset 0x00
// - Switch bits disconnect CO input, gain, output resistors
// - Gain field selects integrated CO feedback resistor
// - Field programs millivolt reference 1.25 to 5 mV
// - 300 mV and millivolt references mutually exclusive
// - Test enable and direction drive reference-pin switches
// - Power-good shows boost above 95% of target
// - Power-good changes only after 200 us persistence while boost is on
// - Power-good low 10 ms after start latches error
// - Power-good reads low while boost disabled
// - Enable or charge bit, unless sleep and sleep-off
// - Low-supply option plus tripped comparator enables boost
// - Regulator error state enables boost unless the MCU disable bit is set
// - Charge bit self-clears once power-good goes high
// - Regulator fault state: error high, disable low
// - Photo reference 50 mV when selected and amplifier or gain enable on
`ifndef AEC_CFG_SVH
`define AEC_CFG_SVH

`define AEC_CLK_MHZ 40
`define AEC_PG_DEGLITCH_US 200
`define AEC_BOOST_TIMEOUT_MS 10

`define AEC_OFS_STATUS 8'h00
`define AEC_OFS_LED_CTRL 8'h04
`define AEC_OFS_LED_CODE 8'h08
`define AEC_OFS_CO_CTRL 8'h0c
`define AEC_OFS_BOOST_CTRL 8'h10

`define AEC_ST_BIN_LSB 0
`define AEC_ST_PG_BIT 4
`define AEC_ST_ERR_BIT 5
`define AEC_ST_MCU_FAULT_BIT 6
`define AEC_ST_BOOST_ON_BIT 7

`define AEC_LED_GATE_BIT 0
`define AEC_LED_SELECT_BIT 1
`define AEC_LED_GPIO_EN_BIT 2
`define AEC_LED_GPIO_TGT_BIT 3
`define AEC_LED_TC_A_LSB 4
`define AEC_LED_TC_B_LSB 6

`define AEC_CO_SW_LSB 0
`define AEC_CO_GAIN_LSB 3
`define AEC_CO_MV_CODE_LSB 8
`define AEC_CO_MV_EN_BIT 10
`define AEC_CO_300MV_EN_BIT 11
`define AEC_CO_TEST_EN_BIT 12
`define AEC_CO_TEST_DIR_BIT 13

`define AEC_BOOST_ENABLE_BIT_BIT 0
`define AEC_BOOST_ONESHOT_CHARGE_BIT 1
`define AEC_BST_SLEEP_OFF_BIT 2
`define AEC_BST_SLEEP_EN_BIT 3
`define AEC_BST_LOW_OPT_BIT 4
`define AEC_BST_MCU_DIS_BIT 5
`define AEC_BST_VSET_LSB 8
`define AEC_BST_PHOTO_INPUT_AMP_ENABLE_BIT 12
`define AEC_BST_PGAIN_EN_BIT 13
`define AEC_BST_PHOTO_REFERENCE_SELECT_BIT 14

`define AEC_LED_CTRL_RESET 8'h00
`define AEC_LED_CODE_RESET 16'h0000
`define AEC_CO_CTRL_RESET 14'h0000
`define AEC_BOOST_CTRL_RESET 15'h0000

`endif

//--- verilog/aec_pkg.sv
/*
  Types of the alarm front-end enable control block.
  Assumes aec_cfg.svh supplies the numeric constants.
*/
package aec_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } aec_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } aec_apb_rsp_type;

  typedef struct packed {
    logic led_enable_pin;
    logic gpio_pin;
    logic boost_power_good_raw;
    logic low_supply_comparator;
    logic mcu_regulator_error;
  } aec_pins_type;

  typedef struct packed {
    logic led_a_on;
    logic led_b_on;
    logic [7:0] led_a_current_code;
    logic [7:0] led_b_current_code;
    logic [1:0] led_a_temp_comp_setting;
    logic [1:0] led_b_temp_comp_setting;
  } aec_led_type;

  typedef struct packed {
    logic [2:0] co_resistor_switches;
    logic [2:0] co_gain_select;
    logic [1:0] co_millivolt_reference;
    logic co_mv_reference_on;
    logic co_300mv_reference_on;
    logic co_test_pullup_on;
    logic co_test_pulldown_on;
    logic photo_reference_50mv_on;
  } aec_co_type;

  typedef struct packed {
    logic boost_on;
    logic [3:0] boost_voltage_setting;
  } aec_boost_type;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [7:0] led_ctrl_reg;
    logic [15:0] led_code_reg;
    logic [13:0] co_ctrl_reg;
    logic [14:0] boost_ctrl_reg;
    logic [3:0] vset_seen;
    logic pg_filt;
    logic [19:0] pg_cnt;
    logic tmo_armed;
    logic [19:0] tmo_cnt;
    logic err_flag;
    aec_apb_rsp_type rsp;
    aec_led_type led;
    aec_co_type co;
    aec_boost_type boost;
  } aec_state_type;

endpackage

//--- verilog/aec_top.sv
/*
  Enable and configuration control of a smoke and CO alarm front end:
  LED driver gating, CO amplifier switches and references, boost enable,
  power-good deglitch and boost error latch, all behind an APB slave.
  Assumes one 40 MHz clock, synchronous active-high reset, asynchronous pins.
*/
`timescale 1ns/1ps
`include "aec_cfg.svh"

module aec_top #(
  parameter int PG_DEGLITCH_CYC = `AEC_PG_DEGLITCH_US * `AEC_CLK_MHZ,
  parameter int BOOST_TIMEOUT_CYC = `AEC_BOOST_TIMEOUT_MS * 1000 * `AEC_CLK_MHZ,
  parameter logic [1:0] SENSE_BIN = 2'h0
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire aec_pkg::aec_apb_req_type APB_REQ,
  output aec_pkg::aec_apb_rsp_type APB_RSP,
  input wire aec_pkg::aec_pins_type PINS,
  output aec_pkg::aec_led_type LED_OUT,
  output aec_pkg::aec_co_type CO_OUT,
  output aec_pkg::aec_boost_type BOOST_OUT,
  output logic BOOST_POWER_GOOD,
  output logic BOOST_ERROR_FLAG
);
  import aec_pkg::*;

  localparam int PIN_LED = 4;
  localparam int PIN_GPIO = 3;
  localparam int PIN_PG = 2;
  localparam int PIN_LOW = 1;
  localparam int PIN_MCU = 0;
  localparam logic [19:0] PG_LAST = 20'(PG_DEGLITCH_CYC - 1);
  localparam logic [19:0] TMO_LAST = 20'(BOOST_TIMEOUT_CYC - 1);

  aec_state_type state_reg;
  aec_state_type state_next;

  logic mcu_fault;
  logic boost_req;
  logic restart;
  logic apb_setup;
  logic apb_write;
  logic [31:0] wdata;

  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == `AEC_OFS_STATUS) || (addr == `AEC_OFS_LED_CTRL) ||
      (addr == `AEC_OFS_LED_CODE) || (addr == `AEC_OFS_CO_CTRL) || (addr == `AEC_OFS_BOOST_CTRL);
  endfunction

  function automatic logic [31:0] read_word(input aec_state_type st, input logic [7:0] addr,
    input logic fault);
    read_word = 32'h0000_0000;
    unique case (addr)
      `AEC_OFS_STATUS:
      begin
        read_word[`AEC_ST_BIN_LSB +: 2] = SENSE_BIN;
        read_word[`AEC_ST_PG_BIT] = st.pg_filt & st.boost.boost_on;
        read_word[`AEC_ST_ERR_BIT] = st.err_flag;
        read_word[`AEC_ST_MCU_FAULT_BIT] = fault;
        read_word[`AEC_ST_BOOST_ON_BIT] = st.boost.boost_on;
      end
      `AEC_OFS_LED_CTRL: read_word[7:0] = st.led_ctrl_reg;
      `AEC_OFS_LED_CODE: read_word[15:0] = st.led_code_reg;
      `AEC_OFS_CO_CTRL: read_word[13:0] = st.co_ctrl_reg;
      `AEC_OFS_BOOST_CTRL: read_word[14:0] = st.boost_ctrl_reg;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  always_comb
  begin
    state_next = state_reg;
    wdata = APB_REQ.pwdata;

    // Two-stage synchroniser for every pin
    state_next.sync1 = PINS;
    state_next.sync2 = state_reg.sync1;

    mcu_fault = state_reg.sync2[PIN_MCU] & ~state_reg.boost_ctrl_reg[`AEC_BST_MCU_DIS_BIT];

    // Boost enable terms
    boost_req = ((state_reg.boost_ctrl_reg[`AEC_BOOST_ENABLE_BIT_BIT] |
      state_reg.boost_ctrl_reg[`AEC_BOOST_ONESHOT_CHARGE_BIT]) &
      ~(state_reg.boost_ctrl_reg[`AEC_BST_SLEEP_OFF_BIT] &
      state_reg.boost_ctrl_reg[`AEC_BST_SLEEP_EN_BIT])) |
      (state_reg.boost_ctrl_reg[`AEC_BST_LOW_OPT_BIT] & state_reg.sync2[PIN_LOW]) |
      mcu_fault;

    // A fresh enable or a new voltage setting starts both counters over
    restart = (boost_req & ~state_reg.boost.boost_on) |
      (state_reg.boost_ctrl_reg[`AEC_BST_VSET_LSB +: 4] != state_reg.vset_seen);
    state_next.vset_seen = state_reg.boost_ctrl_reg[`AEC_BST_VSET_LSB +: 4];

    // APB slave: answer in the first access cycle
    apb_setup = APB_REQ.psel & ~APB_REQ.penable;
    apb_write = APB_REQ.psel & APB_REQ.penable & state_reg.rsp.pready & APB_REQ.pwrite;
    state_next.rsp.pready = apb_setup;
    state_next.rsp.pslverr = apb_setup & ~addr_hit(APB_REQ.paddr);
    state_next.rsp.prdata = apb_setup ? read_word(state_reg, APB_REQ.paddr, mcu_fault) : 32'h0000_0000;

    // Charge bit drops once power-good is seen
    if (state_reg.pg_filt & state_reg.boost.boost_on)
    begin
      state_next.boost_ctrl_reg[`AEC_BOOST_ONESHOT_CHARGE_BIT] = 1'b0;
    end

    if (apb_write)
    begin
      unique case (APB_REQ.paddr)
        `AEC_OFS_STATUS:
        begin
          if (wdata[`AEC_ST_ERR_BIT])
          begin
            state_next.err_flag = 1'b0;
          end
        end
        `AEC_OFS_LED_CTRL: state_next.led_ctrl_reg = wdata[7:0];
        `AEC_OFS_LED_CODE: state_next.led_code_reg = wdata[15:0];
        `AEC_OFS_CO_CTRL:
        begin
          state_next.co_ctrl_reg = wdata[13:0];
          if (wdata[`AEC_CO_300MV_EN_BIT])
          begin
            state_next.co_ctrl_reg[`AEC_CO_MV_EN_BIT] = 1'b0;
          end
        end
        `AEC_OFS_BOOST_CTRL: state_next.boost_ctrl_reg = wdata[14:0];
        default:
        begin
        end
      endcase
    end

    // Power-good deglitch
    if (!state_reg.boost.boost_on)
    begin
      state_next.pg_filt = 1'b0;
      state_next.pg_cnt = 20'h0_0000;
    end
    else if (restart || (state_reg.sync2[PIN_PG] == state_reg.pg_filt))
    begin
      state_next.pg_cnt = 20'h0_0000;
    end
    else if (state_reg.pg_cnt == PG_LAST)
    begin
      state_next.pg_filt = state_reg.sync2[PIN_PG];
      state_next.pg_cnt = 20'h0_0000;
    end
    else
    begin
      state_next.pg_cnt = state_reg.pg_cnt + 20'h0_0001;
    end

    // Start-up timeout; the set is applied after the clear so it wins
    if (restart)
    begin
      state_next.tmo_armed = 1'b1;
      state_next.tmo_cnt = 20'h0_0000;
    end
    else if (!state_reg.boost.boost_on || state_reg.pg_filt)
    begin
      state_next.tmo_armed = 1'b0;
      state_next.tmo_cnt = 20'h0_0000;
    end
    else if (state_reg.tmo_armed)
    begin
      if (state_reg.tmo_cnt == TMO_LAST)
      begin
        state_next.err_flag = 1'b1;
        state_next.tmo_armed = 1'b0;
      end
      else
      begin
        state_next.tmo_cnt = state_reg.tmo_cnt + 20'h0_0001;
      end
    end

    // LED driver outputs
    state_next.led.led_a_on = state_reg.led_ctrl_reg[`AEC_LED_GATE_BIT] &
      ((state_reg.sync2[PIN_LED] & ~state_reg.led_ctrl_reg[`AEC_LED_SELECT_BIT]) |
      (state_reg.led_ctrl_reg[`AEC_LED_GPIO_EN_BIT] & state_reg.sync2[PIN_GPIO] &
      ~state_reg.led_ctrl_reg[`AEC_LED_GPIO_TGT_BIT]));
    state_next.led.led_b_on = state_reg.led_ctrl_reg[`AEC_LED_GATE_BIT] &
      ((state_reg.sync2[PIN_LED] & state_reg.led_ctrl_reg[`AEC_LED_SELECT_BIT]) |
      (state_reg.led_ctrl_reg[`AEC_LED_GPIO_EN_BIT] & state_reg.sync2[PIN_GPIO] &
      state_reg.led_ctrl_reg[`AEC_LED_GPIO_TGT_BIT]));
    state_next.led.led_a_current_code = state_reg.led_code_reg[7:0];
    state_next.led.led_b_current_code = state_reg.led_code_reg[15:8];
    state_next.led.led_a_temp_comp_setting = state_reg.led_ctrl_reg[`AEC_LED_TC_A_LSB +: 2];
    state_next.led.led_b_temp_comp_setting = state_reg.led_ctrl_reg[`AEC_LED_TC_B_LSB +: 2];

    // CO amplifier and test switches
    state_next.co.co_resistor_switches = state_reg.co_ctrl_reg[`AEC_CO_SW_LSB +: 3];
    state_next.co.co_gain_select = state_reg.co_ctrl_reg[`AEC_CO_GAIN_LSB +: 3];
    state_next.co.co_millivolt_reference = state_reg.co_ctrl_reg[`AEC_CO_MV_CODE_LSB +: 2];
    state_next.co.co_300mv_reference_on = state_reg.co_ctrl_reg[`AEC_CO_300MV_EN_BIT];
    state_next.co.co_mv_reference_on = state_reg.co_ctrl_reg[`AEC_CO_MV_EN_BIT] &
      ~state_reg.co_ctrl_reg[`AEC_CO_300MV_EN_BIT];
    state_next.co.co_test_pullup_on = state_reg.co_ctrl_reg[`AEC_CO_TEST_EN_BIT] &
      state_reg.co_ctrl_reg[`AEC_CO_TEST_DIR_BIT];
    state_next.co.co_test_pulldown_on = state_reg.co_ctrl_reg[`AEC_CO_TEST_EN_BIT] &
      ~state_reg.co_ctrl_reg[`AEC_CO_TEST_DIR_BIT];
    state_next.co.photo_reference_50mv_on = state_reg.boost_ctrl_reg[`AEC_BST_PHOTO_REFERENCE_SELECT_BIT] &
      (state_reg.boost_ctrl_reg[`AEC_BST_PHOTO_INPUT_AMP_ENABLE_BIT] |
      state_reg.boost_ctrl_reg[`AEC_BST_PGAIN_EN_BIT]);

    state_next.boost.boost_on = boost_req;
    state_next.boost.boost_voltage_setting = state_reg.boost_ctrl_reg[`AEC_BST_VSET_LSB +: 4];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      state_reg <= '0;
      state_reg.led_ctrl_reg <= `AEC_LED_CTRL_RESET;
      state_reg.led_code_reg <= `AEC_LED_CODE_RESET;
      state_reg.co_ctrl_reg <= `AEC_CO_CTRL_RESET;
      state_reg.boost_ctrl_reg <= `AEC_BOOST_CTRL_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign APB_RSP = state_reg.rsp;
  assign LED_OUT = state_reg.led;
  assign CO_OUT = state_reg.co;
  assign BOOST_OUT = state_reg.boost;
  assign BOOST_POWER_GOOD = state_reg.pg_filt;
  assign BOOST_ERROR_FLAG = state_reg.err_flag;

endmodule // aec_top

//--- verif/aec_boost_model.sv
/*
  Boost converter model for the far side: raw power-good rises a few
  cycles after the boost starts, or stays low while stuck is high.
  Assumes the bench clock and the block's boost_on output.
*/
`timescale 1ns/1ps
module aec_boost_model (
  input wire logic clk,
  input wire logic on,
  input wire logic stuck,
  output logic pg_raw
);
  logic [3:0] ramp_reg;
  always_ff @(posedge clk)
  begin
    ramp_reg <= on ? ramp_reg + 4'(ramp_reg != 4'hf) : 4'h0;
  end
  // Output crosses the threshold only after a short ramp
  assign pg_raw = on && !stuck && ramp_reg > 4'h5;
endmodule // aec_boost_model

//--- verif/aec_top_sva.sv
/*
  Port checker of the enable control block.
  Assumes it is bound to aec_top and shares its count parameters.
*/
`timescale 1ns/1ps
module aec_top_sva #(
  parameter int PG_DEGLITCH_CYC = 8000,
  parameter int BOOST_TIMEOUT_CYC = 400000
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire aec_pkg::aec_apb_req_type APB_REQ,
  input wire aec_pkg::aec_apb_rsp_type APB_RSP,
  input wire aec_pkg::aec_pins_type PINS,
  input wire aec_pkg::aec_led_type LED_OUT,
  input wire aec_pkg::aec_co_type CO_OUT,
  input wire aec_pkg::aec_boost_type BOOST_OUT,
  input wire logic BOOST_POWER_GOOD,
  input wire logic BOOST_ERROR_FLAG
);
  import aec_pkg::*;
  int raw_run;
  int wait_run;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Runs of raw power-good high, and of boost waiting for power-good
  always_ff @(posedge CORE_CLK)
  begin
    raw_run <= (SYS_RST || !PINS.boost_power_good_raw) ? 0 : raw_run + 1;
    wait_run <= (SYS_RST || !BOOST_OUT.boost_on || BOOST_POWER_GOOD ||
      $changed(BOOST_OUT.boost_voltage_setting)) ? 0 : wait_run + 1;
  end
  a_apb_ready: assert property (APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready ##1 !APB_RSP.pready)
    else $error("pready is not one cycle after setup");
  a_apb_unmapped: assert property (APB_RSP.pready && APB_REQ.paddr > 8'h10 |->
    APB_RSP.pslverr && APB_RSP.prdata == 32'h0) else $error("unmapped access not refused");
  a_led_source: assert property (LED_OUT.led_a_on || LED_OUT.led_b_on |->
    $past(PINS.led_enable_pin, 3) || $past(PINS.gpio_pin, 3)) else $error("LED on without an enable pin");
  a_led_one_side: assert property (!$past(PINS.gpio_pin, 3) |->
    !(LED_OUT.led_a_on && LED_OUT.led_b_on)) else $error("enable pin reached both LED drivers");
  a_ref_exclusive: assert property (!(CO_OUT.co_mv_reference_on && CO_OUT.co_300mv_reference_on))
    else $error("both CO references on");
  a_test_switches: assert property (!(CO_OUT.co_test_pullup_on && CO_OUT.co_test_pulldown_on))
    else $error("both test switches on");
  a_pg_off_low: assert property (!BOOST_OUT.boost_on && !$past(BOOST_OUT.boost_on) |-> !BOOST_POWER_GOOD)
    else $error("power good high with boost off");
  a_pg_deglitch: assert property ($rose(BOOST_POWER_GOOD) |-> raw_run >= PG_DEGLITCH_CYC)
    else $error("power good rose before the deglitch time");
  a_err_timeout: assert property ($rose(BOOST_ERROR_FLAG) |-> wait_run >= BOOST_TIMEOUT_CYC - 2)
    else $error("boost error set before the timeout");
  a_err_sticky: assert property (BOOST_ERROR_FLAG && !(APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite &&
    APB_RSP.pready && APB_REQ.paddr == 8'h00 && APB_REQ.pwdata[5]) |=> BOOST_ERROR_FLAG)
    else $error("boost error dropped without a clear");
  c_pg_up: cover property ($rose(BOOST_POWER_GOOD));
  c_err: cover property ($rose(BOOST_ERROR_FLAG));
  c_led_b: cover property (LED_OUT.led_b_on);
endmodule // aec_top_sva
bind aec_top aec_top_sva #(.PG_DEGLITCH_CYC(PG_DEGLITCH_CYC), .BOOST_TIMEOUT_CYC(BOOST_TIMEOUT_CYC)) u_sva (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .PINS(PINS),
  .LED_OUT(LED_OUT), .CO_OUT(CO_OUT), .BOOST_OUT(BOOST_OUT), .BOOST_POWER_GOOD(BOOST_POWER_GOOD),
  .BOOST_ERROR_FLAG(BOOST_ERROR_FLAG));

//--- verif/tb_top.sv
/*
  Self-checking bench of the enable control block, driven over APB.
  Assumes the boost model supplies the raw power-good pin.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import aec_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stuck = 1'b0;
  logic pg_raw, pg, err, serr;
  logic [31:0] q;
  logic [12:0] ex;
  logic [1:0] ab;
  logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  aec_apb_req_type req = '0;
  aec_apb_rsp_type rsp;
  aec_pins_type pins = '0;
  aec_pins_type pin_bus;
  aec_led_type led;
  aec_co_type co;
  aec_boost_type bst;
  int n_fail = 0;
  int compares = 0;
  assign pin_bus = {pins.led_enable_pin, pins.gpio_pin, pg_raw, pins.low_supply_comparator, pins.mcu_regulator_error};
  assign ab = {led.led_a_on, led.led_b_on};
  aec_top #(.PG_DEGLITCH_CYC(4), .BOOST_TIMEOUT_CYC(50), .SENSE_BIN(2'h2)) DUT (.CORE_CLK(clk), .SYS_RST(rst),
    .APB_REQ(req), .APB_RSP(rsp), .PINS(pin_bus), .LED_OUT(led), .CO_OUT(co), .BOOST_OUT(bst),
    .BOOST_POWER_GOOD(pg), .BOOST_ERROR_FLAG(err));
  aec_boost_model u_bst (.clk(clk), .on(bst.boost_on), .stuck(stuck), .pg_raw(pg_raw));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One APB transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    q = rsp.prdata;
    serr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, q)
  endtask
  task automatic wait_v(input int s, input logic v);
    int n;
    n = 0;
    while ((s ? bst.boost_on : pg) !== v && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(s ? "boost on" : "power good", v, s ? bst.boost_on : pg)
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
  initial
  begin
    tick(6);
    rst <= 1'b0;
    tick(1);
    for (int i = 0; i < 5; i++)
      rd(ofs[i], i == 0 ? 32'h2 : 32'h0);
    wr(8'h00, 32'h3);
    rd(8'h00, 32'h2);
    rd(8'h14, 32'h0);
    `CHK("pslverr", 1'b1, serr)
    $display("register test done");
    wr(8'h08, 32'hb4a5);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h04, 32'h90 | 32'(k));
      pins.led_enable_pin <= 1'b1;
      tick(5);
      `CHK("led on", (k == 1) ? 2'b10 : (k == 3) ? 2'b01 : 2'b00, ab)
      pins.led_enable_pin <= 1'b0;
      tick(500);
      `CHK("led off", 2'b00, ab)
    end
    `CHK("led codes", 20'ha5b46, led[19:0])
    for (int t = 0; t < 2; t++)
    begin
      wr(8'h04, 32'h95 | 32'(t << 3));
      pins.gpio_pin <= 1'b1;
      tick(5);
      `CHK("gpio led", t ? 2'b01 : 2'b10, ab)
      pins.gpio_pin <= 1'b0;
      tick(500);
    end
    $display("led test done");
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h0c, 32'h1435 | 32'(k << 8) | (k[0] ? 32'h2000 : 32'h0));
      tick(2);
      ex = 13'h1710 | 13'(k << 5) | (k[0] ? 13'h4 : 13'h2);
      `CHK("co outputs", ex, co)
    end
    wr(8'h0c, 32'h0c00);
    tick(2);
    `CHK("co refs", 13'h8, co)
    wr(8'h10, 32'h5000);
    tick(2);
    `CHK("photo ref", 1'b1, co.photo_reference_50mv_on)
    wr(8'h10, 32'h6000);
    tick(2);
    `CHK("photo ref gain", 1'b1, co.photo_reference_50mv_on)
    wr(8'h10, 32'h4000);
    tick(2);
    `CHK("photo ref off", 1'b0, co.photo_reference_50mv_on)
    $display("co test done");
    wr(8'h10, 32'h0501);
    wait_v(0, 1'b1);
    `CHK("vset", 4'h5, bst.boost_voltage_setting)
    rd(8'h00, 32'h92);
    wr(8'h10, 32'h050d);
    tick(3);
    `CHK("sleep off", 1'b0, bst.boost_on)
    rd(8'h00, 32'h02);
    wr(8'h10, 32'h0502);
    wait_v(0, 1'b1);
    tick(3);
    `CHK("charge off", 1'b0, bst.boost_on)
    rd(8'h10, 32'h0500);
    wr(8'h10, 32'h0510);
    pins.low_supply_comparator <= 1'b1;
    wait_v(1, 1'b1);
    pins.low_supply_comparator <= 1'b0;
    wait_v(1, 1'b0);
    pins.mcu_regulator_error <= 1'b1;
    wait_v(1, 1'b1);
    wait_v(0, 1'b1);
    rd(8'h00, 32'hd2);
    wr(8'h10, 32'h0520);
    wait_v(1, 1'b0);
    pins.mcu_regulator_error <= 1'b0;
    stuck <= 1'b1;
    wr(8'h10, 32'h0301);
    tick(70);
    `CHK("boost error", 1'b1, err)
    rd(8'h00, 32'ha2);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h20);
    `CHK("error clear", 1'b0, err)
    stuck <= 1'b0;
    $display("boost test done");
    test_done();
  end
endmodule // tb_top
